// ### core/cbc_pkg.sv
/*
 * constants, types and helpers for the processor bus cycle control block.
 * assumes a single 40 MHz system clock; one clock state takes two system
 * clocks, the first standing for phase one and the second for phase two.
 */
// Contract
// - reset clears program counter to zero
// - reset clears interrupt flag and grant flag
// - reset leaves datapath registers uninitialised
// - reset held three periods, asynchronous input
// - hold recognised halted or ready in T2/wait
// - granted hold floats address and data buses
// - grant starts third state reads, after writes
// - grant after phase one, float after phase two
// - interrupt sampled at instruction end or halted
// - interrupt ignored in hold or flag clear
// - enable/disable instructions steer flag, flag pinned out
// - accepted interrupt clears flag in next fetch T1
// - interrupting device supplies instruction, all bytes fetched
// - input strobe marks input mode; sources gated by it
// - write strobe low, data valid meanwhile
// - cycle start marker pulses each machine cycle
// - status byte on data bus during marker
// - wait states and stall while ready low
// - address carries memory address or port number
// - fourth/fifth states finish together with hold entry
// - pending interrupt cleared whenever flag cleared
package cbc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TSTATE_NS = 50;
    localparam int RST_MIN_TSTATES = 3;
    localparam int RST_HOLD_CYC = (RST_MIN_TSTATES * TSTATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = $clog2(RST_HOLD_CYC + 1);

    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int SYNC_W = 11;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CK_FETCH = 3'h0,
        CK_MEM_RD = 3'h1,
        CK_MEM_WR = 3'h2,
        CK_IN = 3'h3,
        CK_OUT = 3'h4,
        CK_IRQ_ACK = 3'h5
    } cbc_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h2,
        ST_TW = 3'h3,
        ST_T3 = 3'h4,
        ST_T4 = 3'h5,
        ST_T5 = 3'h6,
        ST_HOLD = 3'h7
    } cbc_state_t;

    typedef struct packed {
        cbc_kind_t kind;       // machine cycle type
        logic [15:0] addr;     // memory address, or port number in low byte
        logic [7:0] wdata;     // write or output data
        logic [7:0] status;    // status byte shown during the marker
        logic long_cyc;        // cycle needs the fourth and fifth states
    } cbc_req_t;

    // ------------------------------------------------------------
    // kind decoding
    // ------------------------------------------------------------
    function automatic logic kind_reads(input cbc_kind_t k);
        kind_reads = (k == CK_FETCH) || (k == CK_MEM_RD) || (k == CK_IN) || (k == CK_IRQ_ACK);
    endfunction : kind_reads

    function automatic logic kind_io(input cbc_kind_t k);
        kind_io = (k == CK_IN) || (k == CK_OUT);
    endfunction : kind_io

endpackage : cbc_pkg

// ### core/cbc_bus_ctrl.sv
/*
 * bus cycle control of an 8-bit processor: reset handling, machine cycle
 * sequencing with status word, input and write strobes, ready wait states,
 * bus hold and grant, interrupt acceptance with its enable flag.
 * assumes the core asks for one machine cycle at a time and reports halt
 * and instruction end; pins arrive asynchronously and are synchronised.
 */
`timescale 1ns/10ps
module cbc_bus_ctrl
    import cbc_pkg::*;
(
    input wire logic clk_i,                  // 40 MHz system clock
    input wire logic reset_i,                // asynchronous reset, active high
    input wire logic req_valid_i,            // core asks for a machine cycle
    input wire cbc_req_t req_i,              // cycle description
    output logic req_ready_o,                // cycle request taken this clock
    output logic done_o,                     // machine cycle finished, one clock
    output logic [7:0] rdata_o,              // byte read in the last cycle
    input wire logic halt_i,                 // core is halted
    input wire logic instr_end_i,            // last cycle of instruction done
    input wire logic irq_on_instr_i,         // enable-interrupts executed
    input wire logic irq_off_instr_i,        // disable-interrupts executed
    input wire logic pc_we_i,                // core loads program counter
    input wire logic [15:0] pc_d_i,          // new program counter
    output logic [15:0] pc_o,                // program counter
    output logic irq_take_o,                 // interrupt accepted, one clock
    output logic [15:0] addr_o,              // address bus
    output logic addr_oe_o,                  // address bus driven
    input wire logic [7:0] data_i,           // data bus input
    output logic [7:0] data_o,               // data bus output
    output logic data_oe_o,                  // data bus driven
    output logic bus_input_strobe_o,         // data bus in input mode
    output logic write_n_o,                  // write strobe, active low
    output logic sync_o,                     // cycle start marker
    output logic stall_o,                    // processor in a wait state
    input wire logic ready_i,                // memory or port ready
    input wire logic hold_i,                 // bus hold request
    input wire logic irq_i,                  // interrupt request
    output logic bus_grant_out_o,            // hold acknowledge
    output logic irq_accept_flag_o,          // interrupt enable flag
    output logic phase2_o                    // high in phase two half of a state
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic rst_hold_r;
    logic [SYNC_W-1:0] pin_meta_r;
    logic [SYNC_W-1:0] pin_sync_r;
    logic ready_s;
    logic hold_s;
    logic irq_s;
    logic [7:0] data_s;
    logic ph_r;
    cbc_state_t st_r;
    cbc_state_t st_nxt;
    cbc_req_t req_r;
    logic hold_ok;
    logic hold_seen_r;
    logic grant_r;
    logic grant_nxt;
    logic float_r;
    logic [15:0] pc_r;
    logic [15:0] addr_r;
    logic [7:0] rdata_r;
    logic done_r;
    logic done_nxt;
    logic flag_r;
    logic flag_nxt;
    logic svc_r;
    logic take_nxt;
    logic take_r;
    logic is_rd;
    logic in_data_phase;
    logic take_req;
    logic ack_t1;

    // ------------------------------------------------------------
    // reset: asynchronous entry, synchronised release, stretched
    // ------------------------------------------------------------
    // a short glitch-free pulse still gives the full minimum hold inside
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rst_sync_r <= 2'b11;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b0};
        end
    end

    // count the minimum hold after the release has been synchronised
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rst_cnt_r <= RST_CNT_W'(RST_HOLD_CYC);
            rst_hold_r <= 1'b1;
        end
        else if (rst_sync_r[1])
        begin
            rst_cnt_r <= RST_CNT_W'(RST_HOLD_CYC);
            rst_hold_r <= 1'b1;
        end
        else
        begin
            rst_cnt_r <= (rst_cnt_r != '0) ? rst_cnt_r - RST_CNT_W'(1) : rst_cnt_r;
            rst_hold_r <= (rst_cnt_r > RST_CNT_W'(1));
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // data is synchronised too, so read data lags the bus by two clocks
    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= {ready_i, hold_i, irq_i, data_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign ready_s = pin_sync_r[10];
    assign hold_s = pin_sync_r[9];
    assign irq_s = pin_sync_r[8];
    assign data_s = pin_sync_r[7:0];

    // ------------------------------------------------------------
    // two-phase clock: each state is a phase one and a phase two clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            ph_r <= 1'b0;
        end
        else
        begin
            ph_r <= ~ph_r;
        end
    end

    // ------------------------------------------------------------
    // machine cycle sequencer
    // ------------------------------------------------------------
    // hold only counts when halted in idle or when ready ends T2 or a wait state
    assign hold_ok = hold_s && ((halt_i && st_r == ST_IDLE) ||
        ((st_r == ST_T2 || st_r == ST_TW) && ready_s));
    assign req_ready_o = (st_r == ST_IDLE) && ph_r && !grant_r && !(hold_s && halt_i) && !rst_hold_r;
    assign take_req = req_valid_i && req_ready_o;
    assign is_rd = kind_reads(req_r.kind);

    // states change only at the end of phase two
    always_comb
    begin
        st_nxt = st_r;
        if (ph_r)
        begin
            case (st_r)
                ST_IDLE:
                begin
                    if (hold_s && halt_i)
                        st_nxt = ST_HOLD;
                    else if (take_req)
                        st_nxt = ST_T1;
                end
                ST_T1: st_nxt = ST_T2;
                ST_T2: st_nxt = ready_s ? ST_T3 : ST_TW;
                ST_TW: st_nxt = ready_s ? ST_T3 : ST_TW;
                ST_T3:
                begin
                    // fourth and fifth states fold into the hold entry
                    if (hold_seen_r)
                        st_nxt = ST_HOLD;
                    else if (req_r.long_cyc)
                        st_nxt = ST_T4;
                    else
                        st_nxt = ST_IDLE;
                end
                ST_T4: st_nxt = ST_T5;
                ST_T5: st_nxt = ST_IDLE;
                ST_HOLD: st_nxt = hold_s ? ST_HOLD : ST_IDLE;
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            st_r <= ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // latch the request and drive its address for the whole cycle
    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            req_r <= '0;
            addr_r <= PC_RESET;
        end
        else if (take_req)
        begin
            req_r <= req_i;
            if (req_i.kind == CK_FETCH || req_i.kind == CK_IRQ_ACK)
                addr_r <= pc_r;
            else if (kind_io(req_i.kind))
                addr_r <= {req_i.addr[7:0], req_i.addr[7:0]};
            else
                addr_r <= req_i.addr;
        end
    end

    // ------------------------------------------------------------
    // hold recognition, grant and float
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            hold_seen_r <= 1'b0;
        end
        else if (ph_r && (st_r == ST_T2 || st_r == ST_TW))
        begin
            hold_seen_r <= hold_ok;
        end
        else if (ph_r && st_r == ST_T3)
        begin
            hold_seen_r <= 1'b0;
        end
    end

    // grant rises at a phase one start: in T3 for reads, after T3 for writes
    always_comb
    begin
        grant_nxt = grant_r;
        if (ph_r)
        begin
            if (st_nxt == ST_HOLD)
                grant_nxt = 1'b1;
            else if (st_nxt == ST_T3 && hold_ok && is_rd)
                grant_nxt = 1'b1;
            else if (st_r == ST_HOLD)
                grant_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            grant_r <= 1'b0;
        end
        else
        begin
            grant_r <= grant_nxt;
        end
    end

    // float one clock later, at the phase two edge of the granted state
    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            float_r <= 1'b0;
        end
        else if (!grant_r)
        begin
            float_r <= 1'b0;
        end
        else if (!ph_r)
        begin
            float_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // cycle completion, read data and program counter
    // ------------------------------------------------------------
    assign done_nxt = ph_r && ((st_r == ST_T3 && (hold_seen_r || !req_r.long_cyc)) || st_r == ST_T5);

    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            done_r <= 1'b0;
            rdata_r <= DATA_RESET;
        end
        else
        begin
            done_r <= done_nxt;
            if (ph_r && st_r == ST_T3 && is_rd)
                rdata_r <= data_s;
        end
    end

    // the program counter resets to zero, as do the flags; datapath registers live in the core
    // and keep their contents through reset
    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            pc_r <= PC_RESET;
        end
        else if (pc_we_i)
        begin
            pc_r <= pc_d_i;
        end
        else if (done_nxt && req_r.kind == CK_FETCH)
        begin
            // bytes injected by the interrupting device do not advance it
            pc_r <= pc_r + PC_STEP;
        end
    end

    // ------------------------------------------------------------
    // interrupt acceptance
    // ------------------------------------------------------------
    assign take_nxt = irq_s && flag_r && !grant_r && !svc_r && (instr_end_i || halt_i);
    assign ack_t1 = (st_r == ST_T1) && (req_r.kind == CK_IRQ_ACK) && svc_r;

    // enable wins over the automatic clear in the same clock
    always_comb
    begin
        flag_nxt = flag_r;
        if (irq_off_instr_i || ack_t1)
            flag_nxt = 1'b0;
        if (irq_on_instr_i)
            flag_nxt = 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_hold_r)
    begin
        if (rst_hold_r)
        begin
            flag_r <= 1'b0;
            svc_r <= 1'b0;
            take_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
            take_r <= take_nxt;
            if (!flag_nxt)
                svc_r <= 1'b0;
            else if (take_nxt)
                svc_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    assign in_data_phase = (st_r == ST_T2) || (st_r == ST_TW) || (st_r == ST_T3);
    assign sync_o = (st_r == ST_T1);
    assign stall_o = (st_r == ST_TW);
    assign bus_input_strobe_o = is_rd && in_data_phase && !float_r;
    assign write_n_o = !(!is_rd && st_r == ST_T3);
    assign addr_oe_o = !float_r;
    assign addr_o = addr_r;
    assign data_oe_o = !float_r && ((st_r == ST_T1) || (!is_rd && in_data_phase));
    assign data_o = (st_r == ST_T1) ? req_r.status : req_r.wdata;
    assign bus_grant_out_o = grant_r;
    assign irq_accept_flag_o = flag_r;
    assign irq_take_o = take_r;
    assign done_o = done_r;
    assign rdata_o = rdata_r;
    assign pc_o = pc_r;
    assign phase2_o = ph_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pc_reset;
        @(posedge clk_i) disable iff (reset_i) $fell(rst_hold_r) |-> pc_o == PC_RESET;
    endproperty
    a_pc_reset: assert property (p_pc_reset) else $error("pc not zero after reset");

    property p_flags_reset;
        @(posedge clk_i) disable iff (reset_i) $fell(rst_hold_r) |-> !irq_accept_flag_o && !bus_grant_out_o;
    endproperty
    a_flags_reset: assert property (p_flags_reset) else $error("flags set after reset");

    property p_reset_len;
        @(posedge clk_i) disable iff (reset_i) $fell(rst_hold_r) |-> $past(rst_hold_r, RST_HOLD_CYC);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("internal reset too short");

    property p_hold_recog;
        @(posedge clk_i) disable iff (rst_hold_r)
            $rose(hold_seen_r) |-> $past(ready_s) && ($past(st_r) == ST_T2 || $past(st_r) == ST_TW);
    endproperty
    a_hold_recog: assert property (p_hold_recog) else $error("hold seen outside allowed states");

    property p_float;
        @(posedge clk_i) disable iff (rst_hold_r) $rose(bus_grant_out_o) |-> !ph_r ##1 !addr_oe_o && !data_oe_o;
    endproperty
    a_float: assert property (p_float) else $error("buses not floated after grant");

    property p_grant_start;
        @(posedge clk_i) disable iff (rst_hold_r)
            $rose(bus_grant_out_o) |-> (st_r == ST_T3 && is_rd) || st_r == ST_HOLD;
    endproperty
    a_grant_start: assert property (p_grant_start) else $error("grant began in wrong state");

    property p_irq_block;
        @(posedge clk_i) disable iff (rst_hold_r) (bus_grant_out_o || !irq_accept_flag_o) |=> !irq_take_o;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("interrupt taken while blocked");

    property p_irq_point;
        @(posedge clk_i) disable iff (rst_hold_r) irq_take_o |-> $past(instr_end_i) || $past(halt_i);
    endproperty
    a_irq_point: assert property (p_irq_point) else $error("interrupt taken mid instruction");

    property p_ack_clear;
        @(posedge clk_i) disable iff (rst_hold_r) (ack_t1 && !irq_on_instr_i) |=> !irq_accept_flag_o;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("flag kept through ack fetch");

    property p_write_data;
        @(posedge clk_i) disable iff (rst_hold_r) !write_n_o |-> data_oe_o && data_o == req_r.wdata;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data not valid");

    property p_status;
        @(posedge clk_i) disable iff (rst_hold_r) $rose(sync_o) |-> sync_o [*2] ##1 !sync_o;
    endproperty
    a_status: assert property (p_status) else $error("marker not one state long");

    property p_status_byte;
        @(posedge clk_i) disable iff (rst_hold_r) sync_o |-> data_oe_o && data_o == req_r.status;
    endproperty
    a_status_byte: assert property (p_status_byte) else $error("status byte missing");

    property p_wait;
        @(posedge clk_i) disable iff (rst_hold_r) (st_r == ST_T2 && ph_r && !ready_s) |=> stall_o [*2];
    endproperty
    a_wait: assert property (p_wait) else $error("no wait state on low ready");

    property p_pend_clear;
        @(posedge clk_i) disable iff (rst_hold_r) !irq_accept_flag_o |-> !svc_r;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending interrupt survived disable");

endmodule : cbc_bus_ctrl

// ### verification/cbc_mem_model.sv
/* memory and port model on the far side of the bus control block.
   assumes the bench resolves the data bus from the processor enable. */
`timescale 1ns/10ps
module cbc_mem_model (
    input wire logic clk_i,         // system clock
    input wire logic [15:0] addr_i, // address bus
    input wire logic strobe_i,      // input strobe
    input wire logic write_n_i,     // write strobe, active low
    input wire logic sync_i,        // cycle start marker
    input wire logic [7:0] wdata_i, // data bus from processor
    input wire logic [7:0] waits_i, // clocks of ready low per cycle
    output logic [7:0] data_o,      // data bus toward processor
    output logic ready_o            // ready pin
);
    logic [7:0] mem_r [256];
    logic [7:0] cnt_r;
    logic [7:0] last_r;
    // known pattern so read data can be predicted
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_r[i] = 8'(i) ^ 8'h5A;
        cnt_r = 8'h00;
        last_r = 8'h00;
    end
    // ready held low a set time after each marker, writes taken while the write strobe is low
    always @(posedge clk_i)
    begin
        if (sync_i)
            cnt_r <= waits_i;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        if (!write_n_i)
            mem_r[addr_i[7:0]] <= wdata_i;
        if (strobe_i)
            last_r <= data_o;
    end
    assign ready_o = (cnt_r == 8'h00);
    // drives only under the strobe; otherwise a pattern, so a stale byte never passes
    assign data_o = strobe_i ? mem_r[addr_i[7:0]] : ~last_r;
endmodule : cbc_mem_model

// ### verification/tb_cbc_bus_ctrl.sv
/* self-checking bench for the bus cycle control block.
   assumes the memory model answers every read and write cycle. */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_cbc_bus_ctrl
    import cbc_pkg::*;
();
    logic clk_i, reset_i, req_valid, req_ready, done, irq_take, addr_oe, data_oe, strobe, write_n, sync, stall;
    logic ready, hold, irq, grant, flag, seen, saw_stall, halt, ph2;
    logic [2:0] pls;
    logic [7:0] rdata, data_o, mem_data, waits, s_stat;
    logic [15:0] pc, addr, s_addr;
    cbc_req_t req;
    int num_errors, total_checks, cyc_cnt;
    cbc_bus_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid), .req_i(req),
        .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .halt_i(halt), .instr_end_i(pls[0]),
        .irq_on_instr_i(pls[2]), .irq_off_instr_i(pls[1]), .pc_we_i(1'b0), .pc_d_i(16'h0000), .pc_o(pc),
        .irq_take_o(irq_take), .addr_o(addr), .addr_oe_o(addr_oe), .data_i(data_oe ? data_o : mem_data),
        .data_o(data_o), .data_oe_o(data_oe), .bus_input_strobe_o(strobe), .write_n_o(write_n), .sync_o(sync),
        .stall_o(stall), .ready_i(ready), .hold_i(hold), .irq_i(irq), .bus_grant_out_o(grant),
        .irq_accept_flag_o(flag), .phase2_o(ph2));
    cbc_mem_model i_mem (.clk_i(clk_i), .addr_i(addr), .strobe_i(strobe), .write_n_i(write_n), .sync_i(sync),
        .wdata_i(data_o), .waits_i(waits), .data_o(mem_data), .ready_o(ready));
    always #12.5 clk_i = ~clk_i;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // hang guard, well above the few hundred clocks the tests need
    always @(posedge clk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    // one machine cycle: wait for take, then watch marker, stall and write strobe
    task automatic cyc(input cbc_kind_t k, input logic [15:0] a, input logic [7:0] w, input logic [7:0] nw);
        int n;
        n = 0;
        saw_stall = 1'b0;
        waits <= nw;
        req <= '{kind: k, addr: a, wdata: w, status: 8'(k), long_cyc: 1'b0};
        req_valid <= 1'b1;
        do @(posedge clk_i); while (req_ready !== 1'b1 && ++n < 100);
        `CHK("take phase", 1'b1, ph2)
        req_valid <= 1'b0;
        while (done !== 1'b1 && ++n < 300)
        begin
            @(posedge clk_i);
            if (sync === 1'b1)
            begin
                s_addr = addr;
                s_stat = data_o;
            end
            saw_stall = saw_stall | (stall === 1'b1);
            if (write_n === 1'b0)
                `CHK("write data", w, data_o)
        end
        if (n >= 300)
            num_errors++;
    endtask : cyc
    // short instruction pulses, recording any interrupt take meanwhile
    task automatic pulse(input logic [2:0] v);
        seen = 1'b0;
        pls <= v;
        repeat (8)
        begin
            @(posedge clk_i);
            // drop the pulse only once, so a following call can raise it at once
            if (pls != 3'b000)
                pls <= 3'b000;
            seen = seen | (irq_take === 1'b1);
        end
    endtask : pulse
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 0;
        reset_i = 1;
        req_valid = 0;
        req = '0;
        pls = 0;
        hold = 0;
        halt = 0;
        irq = 0;
        waits = 0;
        num_errors = 0;
        total_checks = 0;
        cyc_cnt = 0;
        repeat (20) @(posedge clk_i);
        `CHK("pc in reset", 16'h0000, pc)
        `CHK("grant in reset", 1'b0, grant)
        `CHK("flag in reset", 1'b0, flag)
        reset_i <= 1'b0;
        cyc(CK_FETCH, 16'hFFFF, 8'h00, 8'h00);
        `CHK("fetch addr", 16'h0000, s_addr)
        `CHK("status", 8'(CK_FETCH), s_stat)
        `CHK("fetch data", 8'h5A, rdata)
        `CHK("no stall", 1'b0, saw_stall)
        $display("test reset and fetch done");
        cyc(CK_MEM_RD, 16'h1234, 8'h00, 8'h06);
        `CHK("stall", 1'b1, saw_stall)
        `CHK("slow read", 8'h6E, rdata)
        `CHK("status rd", 8'(CK_MEM_RD), s_stat)
        cyc(CK_MEM_WR, 16'h0042, 8'hC3, 8'h00);
        cyc(CK_IN, 16'h0042, 8'h00, 8'h00);
        `CHK("port addr", 16'h4242, s_addr)
        `CHK("in data", 8'hC3, rdata)
        $display("test read write port done");
        hold <= 1'b1;
        cyc(CK_MEM_RD, 16'h0010, 8'h00, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK("grant", 1'b1, grant)
        `CHK("addr float", 1'b0, addr_oe)
        `CHK("data float", 1'b0, data_oe)
        hold <= 1'b0;
        repeat (8) @(posedge clk_i);
        `CHK("grant off", 1'b0, grant)
        $display("test hold done");
        irq <= 1'b1;
        pulse(3'b100);
        `CHK("flag on", 1'b1, flag)
        `CHK("no take mid instr", 1'b0, seen)
        pulse(3'b001);
        `CHK("take", 1'b1, seen)
        cyc(CK_IRQ_ACK, 16'h0000, 8'h00, 8'h00);
        `CHK("flag auto clear", 1'b0, flag)
        `CHK("pc kept", 16'h0001, pc)
        pulse(3'b100);
        pulse(3'b010);
        `CHK("flag off", 1'b0, flag)
        pulse(3'b001);
        `CHK("ignored", 1'b0, seen)
        pulse(3'b100);
        halt <= 1'b1;
        pulse(3'b000);
        `CHK("halt take", 1'b1, seen)
        hold <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK("halt grant", 1'b1, grant)
        $display("test interrupt done");
        end_sim();
    end
endmodule : tb_cbc_bus_ctrl
